//--- uart_dev_end.sv
// Purpose: device end: command words, framing, wakeup, errors, block check
// Assumes: host loads all command words before any transfer
// Notes: one transmit holding byte; receive FIFO of FIFO_DEPTH bytes
`timescale 1ns/1ps
// Operation
// - mode word bit D2 selects wakeup mode
// - byte after a mode word with D2 set is station address
// - wakeup mode adds a ninth bit
// - first block byte compared with station address
// - unaddressed receiver takes only ninth-bit-one characters
// - master sends target address as block's first
// - parity mismatch sets D5, character still stored
// - missing stop sets D3, character still stored
// - full FIFO: set D4, drop new character
// - check word mismatch sets D6
// - error flags hold until mode word D4
// - check polynomial x^16 + x^12 + x^5 + 1
// - check covers data characters only
// - block: length field plus one data bytes, then two check bytes
// - command chosen by data bits D7, D6
// - parity wins when parity and check enabled
// - stop bits sent equal field plus one
// - format D1 makes next byte the divisor
// - start, data, wake, parity, stop order
// - host configures fully before any transfer
// - ninth bit one only on block's first
module uart_dev_end #(
  parameter int FIFO_DEPTH = uart_pkg::RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // host register port
  input wire logic cmd_sel_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // serial link
  uart_link_if.dev link
);
  import uart_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);

  logic stop2_q, par_en_q, par_odd_q, crc_en_q;
  logic txen_q, rxen_q, wake_q, exp_div_q, exp_addr_q;
  logic [7:0] div_q, addr_q;
  logic [BLK_W-1:0] blk_q;

  // command decode; a pending second byte takes the write first
  wire cmd_any = wr_i & cmd_sel_i;
  wire cmd_wr = cmd_any & ~exp_div_q & ~exp_addr_q;
  wire [1:0] cmd_code = wdata_i[CMD_MSB:CMD_LSB];
  wire wr_fmt = cmd_wr & (cmd_code == CMD_FMT);
  wire wr_blk = cmd_wr & (cmd_code == CMD_BLK);
  wire wr_mode = cmd_wr & (cmd_code == CMD_MODE);
  wire err_clr = wr_mode & wdata_i[MODE_ERR_CLR];
  wire crc_on = crc_en_q & ~par_en_q;

  // configuration words
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {stop2_q, par_en_q, par_odd_q, crc_en_q} <= 4'h0;
      {txen_q, rxen_q, wake_q} <= 3'h0;
      div_q <= DIV_RST;
      addr_q <= 8'h00;
      blk_q <= BLK_RST;
    end
    else
    begin
      if (wr_fmt)
      begin
        stop2_q <= wdata_i[FMT_STOP2];
        par_en_q <= wdata_i[FMT_PAR_EN];
        par_odd_q <= wdata_i[FMT_PAR_ODD];
        crc_en_q <= wdata_i[FMT_CRC_EN];
      end
      if (wr_blk)
        blk_q <= wdata_i[BLK_W-1:0];
      if (wr_mode)
      begin
        txen_q <= wdata_i[MODE_TXEN];
        rxen_q <= wdata_i[MODE_RXEN];
        wake_q <= wdata_i[MODE_WAKE];
      end
      if (cmd_any && exp_div_q)
        div_q <= wdata_i;
      if (cmd_any && exp_addr_q)
        addr_q <= wdata_i;
    end
  end

  // second-byte expectations
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      exp_div_q <= 1'b0;
      exp_addr_q <= 1'b0;
    end
    else
    begin
      exp_div_q <= (wr_fmt & wdata_i[FMT_BAUD_NEXT])
        | (exp_div_q & ~cmd_any);
      exp_addr_q <= (wr_mode & wdata_i[MODE_WAKE])
        | (exp_addr_q & ~cmd_any);
    end
  end

  // bit time in clocks: (divisor + 1) * 16
  wire [12:0] bit_cyc = 13'({5'h0, div_q} + 13'h1) << OVS_SH;
  wire [12:0] half_cyc = bit_cyc >> 1;

  // transmit side
  tx_state_t tx_st_q;
  logic [7:0] hold_q;
  logic hold_v_q, tx_first_q;
  logic [FRAME_W-1:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [12:0] tx_cnt_q;
  logic [BLK_W-1:0] tx_bcnt_q;
  logic [1:0] tx_ph_q;
  logic [15:0] tx_crc_q, tx_crc_nx;

  wire data_wr = wr_i & ~cmd_sel_i & ~hold_v_q;
  wire tx_go = (tx_st_q == TX_IDLE)
    & ((tx_ph_q != PH_DATA) | (hold_v_q & txen_q));
  wire [7:0] tx_byte = (tx_ph_q == PH_HI) ? tx_crc_q[15:8]
    : (tx_ph_q == PH_LO) ? tx_crc_q[7:0] : hold_q;
  wire tx_wb = tx_first_q & (tx_ph_q == PH_DATA);
  wire tx_pb = ^tx_byte ^ par_odd_q;
  wire tx_last = (tx_bcnt_q == blk_q);
  wire tx_tick = (tx_st_q == TX_SEND) & (tx_cnt_q == 13'h1);

  // check word over data characters only
  crc16_step u_tx_crc (
    .crc_i(tx_crc_q),
    .data_i(hold_q),
    .crc_o(tx_crc_nx)
  );

  // frame shifter; wake and parity bits slot in by mode
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= '1;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 13'h0;
    end
    else
    begin
      unique case (tx_st_q)
        TX_IDLE:
          if (tx_go)
          begin
            tx_sh_q <= build_frame(tx_byte, wake_q, tx_wb,
              par_en_q, tx_pb);
            tx_left_q <= frame_len(wake_q, par_en_q, stop2_q);
            tx_cnt_q <= bit_cyc;
            tx_st_q <= TX_SEND;
          end
        TX_SEND:
          if (tx_tick)
          begin
            tx_sh_q <= {1'b1, tx_sh_q[FRAME_W-1:1]};
            tx_left_q <= tx_left_q - 4'h1;
            tx_cnt_q <= bit_cyc;
            if (tx_left_q == 4'h1)
              tx_st_q <= TX_IDLE;
          end
          else
            tx_cnt_q <= tx_cnt_q - 13'h1;
      endcase
    end
  end

  // block sequencing on the transmit side
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_q <= 8'h00;
      hold_v_q <= 1'b0;
      tx_first_q <= 1'b1;
      tx_bcnt_q <= '0;
      tx_ph_q <= PH_DATA;
      tx_crc_q <= CRC_INIT;
    end
    else
    begin
      if (data_wr)
      begin
        hold_q <= wdata_i;
        hold_v_q <= 1'b1;
      end
      else if (tx_go && tx_ph_q == PH_DATA)
      begin
        hold_v_q <= 1'b0;
        // restart at a block end so a later checked block starts clean
        tx_crc_q <= (tx_last && !crc_on) ? CRC_INIT : tx_crc_nx;
        tx_first_q <= tx_last & ~crc_on;
        tx_bcnt_q <= tx_last ? '0 : tx_bcnt_q + 1'b1;
        if (tx_last && crc_on)
          tx_ph_q <= PH_HI;
      end
      else if (tx_go)
      begin
        tx_ph_q <= (tx_ph_q == PH_HI) ? PH_LO : PH_DATA;
        tx_first_q <= (tx_ph_q == PH_LO);
        if (tx_ph_q == PH_LO)
          tx_crc_q <= CRC_INIT;
      end
    end
  end

  assign link.dev_tx = tx_sh_q[0];

  // receive side; first flop feeds only the second
  logic rx_s1_q, rx_s2_q, rx_done_q, addressed_q;
  rx_state_t rx_st_q;
  logic [FRAME_W-1:0] rx_sh_q;
  logic [3:0] rx_left_q;
  logic [12:0] rx_cnt_q;
  logic [BLK_W-1:0] rx_bcnt_q;
  logic [1:0] rx_ph_q;
  logic [15:0] rx_crc_q, rx_crc_nx;
  logic [7:0] rx_hi_q;
  logic par_err_q, frm_err_q, ovr_err_q, crc_err_q;

  wire [3:0] rx_len = frame_len(wake_q, par_en_q, 1'b0);
  wire [FRAME_W-1:0] rx_al = rx_sh_q >> (FRAME_W4 - rx_len);
  wire [7:0] rx_data = rx_al[8:1];
  wire rx_wb = wake_q & rx_al[WAKE_IDX];
  wire [3:0] p_idx = WAKE_IDX + {3'h0, wake_q};
  wire [3:0] s_idx = p_idx + {3'h0, par_en_q};
  wire rx_perr = par_en_q & (rx_al[p_idx] != (^rx_data ^ par_odd_q));
  wire rx_ferr = ~rx_al[s_idx];
  // a ninth bit of one opens a fresh block
  wire rx_new = rx_done_q & rx_wb;
  wire accept = ~wake_q | rx_wb | addressed_q;
  wire [1:0] rx_eph = rx_wb ? PH_DATA : rx_ph_q;
  wire [BLK_W-1:0] rx_eb = rx_wb ? '0 : rx_bcnt_q;
  wire [15:0] rx_ec = rx_wb ? CRC_INIT : rx_crc_q;
  wire rx_char = rx_done_q & accept & (rx_eph == PH_DATA);
  wire rx_last = (rx_eb == blk_q);

  crc16_step u_rx_crc (
    .crc_i(rx_ec),
    .data_i(rx_data),
    .crc_o(rx_crc_nx)
  );

  // receive FIFO
  logic [7:0] mem_q [FIFO_DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] fcnt_q;
  wire fifo_full = (fcnt_q == (PW+1)'(FIFO_DEPTH));
  wire fifo_empty = (fcnt_q == '0);
  wire push = rx_char & ~fifo_full;
  wire pop = rd_i & ~cmd_sel_i & ~fifo_empty;
  wire ovr_set = rx_char & fifo_full;

  // line sampler: mid-bit after the start edge
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {rx_s1_q, rx_s2_q} <= 2'b11;
      rx_st_q <= RX_IDLE;
      rx_sh_q <= '1;
      rx_left_q <= 4'h0;
      rx_cnt_q <= 13'h0;
      rx_done_q <= 1'b0;
    end
    else
    begin
      rx_s1_q <= link.stn_tx;
      rx_s2_q <= rx_s1_q;
      rx_done_q <= 1'b0;
      unique case (rx_st_q)
        RX_IDLE:
          if (rxen_q && !rx_s2_q)
          begin
            rx_cnt_q <= half_cyc;
            rx_left_q <= rx_len;
            rx_st_q <= RX_BUSY;
          end
        RX_BUSY:
          if (rx_cnt_q == 13'h1)
          begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[FRAME_W-1:1]};
            rx_left_q <= rx_left_q - 4'h1;
            rx_cnt_q <= bit_cyc;
            if (rx_left_q == 4'h1)
            begin
              rx_done_q <= 1'b1;
              rx_st_q <= RX_IDLE;
            end
          end
          else
            rx_cnt_q <= rx_cnt_q - 13'h1;
      endcase
    end
  end

  // character handling, address match and block check
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      addressed_q <= 1'b0;
      rx_bcnt_q <= '0;
      rx_ph_q <= PH_DATA;
      rx_crc_q <= CRC_INIT;
      rx_hi_q <= 8'h00;
    end
    else if (rx_done_q && accept)
    begin
      if (rx_new)
        addressed_q <= (rx_data == addr_q);
      if (rx_eph == PH_DATA)
      begin
        rx_crc_q <= rx_last ? (crc_on ? rx_crc_nx : CRC_INIT) : rx_crc_nx;
        rx_bcnt_q <= rx_last ? '0 : rx_eb + 1'b1;
        rx_ph_q <= (rx_last && crc_on) ? PH_HI : PH_DATA;
      end
      else if (rx_eph == PH_HI)
      begin
        rx_hi_q <= rx_data;
        rx_ph_q <= PH_LO;
      end
      else
      begin
        rx_ph_q <= PH_DATA;
        rx_crc_q <= CRC_INIT;
      end
    end
  end

  // sticky errors: a set in the clear cycle wins
  wire crc_set = rx_done_q & accept & (rx_eph == PH_LO)
    & ({rx_hi_q, rx_data} != rx_crc_q);
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {par_err_q, frm_err_q, ovr_err_q, crc_err_q} <= 4'h0;
    else
    begin
      par_err_q <= (push & rx_perr) | (par_err_q & ~err_clr);
      frm_err_q <= (push & rx_ferr) | (frm_err_q & ~err_clr);
      ovr_err_q <= ovr_set | (ovr_err_q & ~err_clr);
      crc_err_q <= crc_set | (crc_err_q & ~err_clr);
    end
  end

  // FIFO storage; an errored character is still stored
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_q[wp_q] <= rx_data;
  end

  wire [7:0] status = {1'b0, crc_err_q, par_err_q, ovr_err_q, frm_err_q,
    ~hold_v_q, fifo_full, ~fifo_empty};

  // pointers and registered read data
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      fcnt_q <= '0;
      rdata_o <= 8'h00;
    end
    else
    begin
      if (push)
        wp_q <= PW'((wp_q + 1'b1) % FIFO_DEPTH);
      if (pop)
        rp_q <= PW'((rp_q + 1'b1) % FIFO_DEPTH);
      fcnt_q <= fcnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      if (rd_i)
        rdata_o <= cmd_sel_i ? status : (fifo_empty ? 8'h00 : mem_q[rp_q]);
    end
  end
endmodule

//--- uart_pkg.sv
// Purpose: shared constants, state types and frame helpers for both ends
// Assumes: one clock, 8-bit data characters sent least significant first
// Notes: command codes sit in data bits 7:6 of a command byte
package uart_pkg;

  // command codes in bits 7:6 of a command byte
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 6;
  localparam logic [1:0] CMD_FMT = 2'h0;
  localparam logic [1:0] CMD_BLK = 2'h1;
  localparam logic [1:0] CMD_MODE = 2'h2;
  localparam logic [1:0] CMD_AUX = 2'h3;

  // format word fields
  localparam int FMT_BAUD_NEXT = 1;
  localparam int FMT_CRC_EN = 2;
  localparam int FMT_PAR_EN = 3;
  localparam int FMT_PAR_ODD = 4;
  localparam int FMT_STOP2 = 5;

  // mode word fields
  localparam int MODE_TXEN = 0;
  localparam int MODE_RXEN = 1;
  localparam int MODE_WAKE = 2;
  localparam int MODE_ERR_CLR = 4;

  // status word fields
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_FRAME = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_PARITY = 5;
  localparam int ST_CRC = 6;

  // block length field and sizes
  localparam int BLK_W = 6;
  localparam int RX_FIFO_DEPTH = 4;
  localparam int OVS_SH = 4;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [BLK_W-1:0] BLK_RST = 6'h00;

  // check word, x^16 + x^12 + x^5 + 1, msb first
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // frame shape: start, 8 data, one stop at least
  localparam int FRAME_W = 12;
  localparam logic [3:0] FRAME_W4 = 4'hc;
  localparam logic [3:0] FRAME_BASE = 4'ha;
  localparam logic [3:0] WAKE_IDX = 4'h9;

  // check byte phases of a block
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_HI = 2'h1;
  localparam logic [1:0] PH_LO = 2'h2;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} rx_state_t;

  // frame bits in line order from bit 0; unused tail reads as mark
  function automatic logic [FRAME_W-1:0] build_frame(
    input logic [7:0] d, input logic wk, input logic wb,
    input logic pe, input logic pb);
    logic [FRAME_W-1:0] f;
    f = {3'b111, d, 1'b0};
    if (wk && pe)
      f = {1'b1, pb, wb, d, 1'b0};
    else if (wk)
      f = {2'b11, wb, d, 1'b0};
    else if (pe)
      f = {2'b11, pb, d, 1'b0};
    return f;
  endfunction

  // number of bit times in a frame
  function automatic logic [3:0] frame_len(
    input logic wk, input logic pe, input logic s2);
    return FRAME_BASE + {3'h0, wk} + {3'h0, pe} + {3'h0, s2};
  endfunction

endpackage

//--- uart_link_if.sv
// Purpose: serial lines between the device and the remote station
// Assumes: both ends share one clock
// Notes: lines idle at mark (high)
`timescale 1ns/1ps
interface uart_link_if;
  logic dev_tx;
  logic stn_tx;
  modport dev (output dev_tx, input stn_tx);
  modport stn (input dev_tx, output stn_tx);
endinterface

//--- crc16_step.sv
// Purpose: one data character folded into the 16-bit check word
// Assumes: msb of the character enters first
// Notes: purely combinational
`timescale 1ns/1ps
module crc16_step
  import uart_pkg::*;
(
  // running value and character
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  // updated value
  output logic [15:0] crc_o
);
  logic [15:0] c [0:8];

  assign c[0] = crc_i;
  // one polynomial division step per data bit
  for (genvar i = 0; i < 8; i++)
  begin : g_bit
    assign c[i+1] = {c[i][14:0], 1'b0}
      ^ ((c[i][15] ^ data_i[7-i]) ? CRC_POLY : 16'h0000);
  end
  assign crc_o = c[8];
endmodule

//--- uart_stn_end.sv
// Purpose: remote station end: sends and receives framed characters
// Assumes: configuration inputs match the device's programmed format
// Notes: no block check here; user logic supplies check bytes itself
`timescale 1ns/1ps
module uart_stn_end (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // line format
  input wire logic [7:0] div_i,
  input wire logic wake_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  input wire logic stop2_i,
  // transmit request
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_first_i,
  output logic tx_ready_o,
  // received characters
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  // serial link
  uart_link_if.stn link
);
  import uart_pkg::*;

  wire [12:0] bit_cyc = 13'({5'h0, div_i} + 13'h1) << OVS_SH;
  wire [12:0] half_cyc = bit_cyc >> 1;

  // transmitter; ninth bit marks the address byte
  logic [FRAME_W-1:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [12:0] tx_cnt_q;
  wire tx_pb = ^tx_byte_i ^ par_odd_i;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_sh_q <= '1;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 13'h0;
      tx_ready_o <= 1'b0;
    end
    else if (tx_left_q == 4'h0)
    begin
      // ready from the cycle after the shifter empties; a held request is never lost
      tx_ready_o <= 1'b1;
      if (tx_valid_i && tx_ready_o)
      begin
        tx_sh_q <= build_frame(tx_byte_i, wake_i, tx_first_i,
          par_en_i, tx_pb);
        tx_left_q <= frame_len(wake_i, par_en_i, stop2_i);
        tx_cnt_q <= bit_cyc;
        tx_ready_o <= 1'b0;
      end
    end
    else if (tx_cnt_q == 13'h1)
    begin
      tx_sh_q <= {1'b1, tx_sh_q[FRAME_W-1:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q <= bit_cyc;
    end
    else
      tx_cnt_q <= tx_cnt_q - 13'h1;
  end
  assign link.stn_tx = tx_sh_q[0];

  // receiver keeps only the data character
  logic rx_s1_q, rx_s2_q;
  logic [FRAME_W-1:0] rx_sh_q;
  logic [3:0] rx_left_q;
  logic [12:0] rx_cnt_q;
  wire [3:0] rx_len = frame_len(wake_i, par_en_i, 1'b0);
  wire [FRAME_W-1:0] rx_nx = {rx_s2_q, rx_sh_q[FRAME_W-1:1]};
  wire [FRAME_W-1:0] rx_al = rx_nx >> (FRAME_W4 - rx_len);
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {rx_s1_q, rx_s2_q} <= 2'b11;
      rx_sh_q <= '1;
      rx_left_q <= 4'h0;
      rx_cnt_q <= 13'h0;
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end
    else
    begin
      rx_s1_q <= link.dev_tx;
      rx_s2_q <= rx_s1_q;
      rx_valid_o <= 1'b0;
      if (rx_left_q == 4'h0)
      begin
        if (!rx_s2_q)
        begin
          rx_left_q <= rx_len;
          rx_cnt_q <= half_cyc;
        end
      end
      else if (rx_cnt_q == 13'h1)
      begin
        rx_sh_q <= rx_nx;
        rx_left_q <= rx_left_q - 4'h1;
        rx_cnt_q <= bit_cyc;
        if (rx_left_q == 4'h1)
        begin
          rx_valid_o <= 1'b1;
          rx_byte_o <= rx_al[8:1];
        end
      end
      else
        rx_cnt_q <= rx_cnt_q - 13'h1;
    end
  end
endmodule

//--- uart_link_chk.sv
// Purpose: timing checks on both serial wires of the joined link
// Assumes: divisor 0 or 1, so one bit lasts 16 or 32 clocks
// Notes: sees the wires only; host port is judged by the bench
`timescale 1ns/1ps
module uart_link_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // serial wires
  input wire logic dev_tx,
  input wire logic stn_tx
);
  // longest legal low run: start, 8 data, wake, parity at 32 clocks
  localparam int LOW_MAX = 352;
  logic [11:0] dev_low_q;
  logic [11:0] stn_low_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // low run counters, read back when the line rises
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dev_low_q <= 12'h000;
      stn_low_q <= 12'h000;
    end
    else
    begin
      dev_low_q <= dev_tx ? 12'h000 : dev_low_q + 12'h001;
      stn_low_q <= stn_tx ? 12'h000 : stn_low_q + 12'h001;
    end
  end
  // a start bit spans at least one full 16-clock bit time
  sequence s_bit_low(x);
    (!x)[*8] ##1 (!x)[*8];
  endsequence
  sequence s_idle(x);
    x[*4];
  endsequence
  a_dev_rst_idle: assert property ($rose(rstn_i) |-> s_idle(dev_tx))
    else $error("device line not idle after reset");
  a_stn_rst_idle: assert property ($rose(rstn_i) |-> s_idle(stn_tx))
    else $error("station line not idle after reset");
  a_dev_start_full: assert property ($fell(dev_tx) |-> s_bit_low(dev_tx))
    else $error("device start bit too short");
  a_stn_start_full: assert property ($fell(stn_tx) |-> s_bit_low(stn_tx))
    else $error("station start bit too short");
  // low stretches are whole multiples of 16 clocks, never fractions
  a_dev_low_whole: assert property ($rose(dev_tx) |->
    dev_low_q[3:0] == 4'h0 && dev_low_q != 12'h000)
    else $error("device low run not whole bits");
  a_stn_low_whole: assert property ($rose(stn_tx) |->
    stn_low_q[3:0] == 4'h0 && stn_low_q != 12'h000)
    else $error("station low run not whole bits");
  // a stop bit must come before the line stays low too long
  a_dev_stop_bound: assert property ($fell(dev_tx) |-> ##[16:LOW_MAX] dev_tx)
    else $error("device frame lacks stop bit");
  a_stn_stop_bound: assert property ($fell(stn_tx) |-> ##[16:LOW_MAX] stn_tx)
    else $error("station frame lacks stop bit");
endmodule

//--- tb_top.sv
// Purpose: drives host port and station user side, checks the wire
// Assumes: 200 MHz clock, divisor 0 or 1
// Notes: a second device shares host strobes; its line is bit-banged
`timescale 1ns/1ps
module tb_top;
  import uart_pkg::*;
  logic mclk_i = 0, rstn_i = 0, cmd_sel = 0, wr = 0, rd = 0, bang_q = 1;
  logic [7:0] wdata = 8'h00, div = 8'h00, tbyte = 8'h00, adr = 8'h00;
  logic wk = 0, pe = 0, po = 0, s2 = 0, tvalid = 0, tfirst = 0;
  logic tready, rvalid;
  logic [7:0] rdata_a, rdata_b, rbyte;
  logic [7:0] rxq[$];
  int bad_count = 0, n_tests = 0, cyc = 0, seed = 67522;
  uart_link_if link();
  uart_link_if link_b();
  assign link_b.stn_tx = bang_q;
  uart_dev_end i_uart_dev_end (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .cmd_sel_i(cmd_sel), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata_a), .link(link));
  uart_dev_end i_uart_dev_end_b (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .cmd_sel_i(cmd_sel), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata_b), .link(link_b));
  uart_stn_end i_uart_stn_end (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .div_i(div), .wake_i(wk), .par_en_i(pe), .par_odd_i(po), .stop2_i(s2),
    .tx_valid_i(tvalid), .tx_byte_i(tbyte), .tx_first_i(tfirst),
    .tx_ready_o(tready), .rx_valid_o(rvalid), .rx_byte_o(rbyte),
    .link(link));
  uart_link_chk i_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .dev_tx(link.dev_tx), .stn_tx(link.stn_tx));
  always #2.5 mclk_i = ~mclk_i;
  // station capture and hang limit
  always @(posedge mclk_i)
  begin
    cyc++;
    if (rvalid === 1'b1)
      rxq.push_back(rbyte);
    if (cyc == 60000)
    begin
      $display("[ERR] %0t run did not finish in time", $time);
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one write strobe, then a quiet cycle so strobes never collide
  task automatic put(input logic c, input logic [7:0] v);
    cmd_sel <= c;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic get(input logic c, input logic sel_b, input logic [7:0] e);
    cmd_sel <= c;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    chk(sel_b ? rdata_b : rdata_a, e);
    @(posedge mclk_i);
  endtask
  // request held until ready is seen at an edge
  task automatic stx(input logic [7:0] b, input logic f);
    tbyte <= b;
    tfirst <= f;
    tvalid <= 1'b1;
    @(posedge mclk_i);
    while (tready !== 1'b1)
      @(posedge mclk_i);
    tvalid <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic bang(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
    begin
      bang_q <= f[i];
      repeat (16) @(posedge mclk_i);
    end
    bang_q <= 1'b1;
  endtask
  // format, divisor, mode (clears errors), address when waking
  task automatic cfg(input logic [7:0] f, input logic [7:0] m,
                     input logic [7:0] dv);
    div <= dv;
    wk <= m[2];
    pe <= f[3];
    po <= f[4];
    s2 <= f[5];
    put(1'b1, f | 8'h02);
    put(1'b1, dv);
    put(1'b1, m | 8'h93);
    if (m[2])
      put(1'b1, adr);
  endtask
  // expected line bits, lsb first, tail padded with mark
  function automatic logic [12:0] frm(input logic [7:0] d, input logic w);
    logic [12:0] f;
    int i;
    f = {4'hf, d, 1'b0};
    i = 9;
    if (wk)
    begin
      f[i] = w;
      i++;
    end
    if (pe)
      f[i] = ^d ^ po;
    return f;
  endfunction
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic samp(input int n, input int bt, output logic [25:0] s);
    s = '1;
    @(negedge link.dev_tx);
    repeat (bt / 2) @(posedge mclk_i);
    for (int i = 0; i < 2 * n; i++)
    begin
      s[(i / n) * 13 + i % n] = link.dev_tx;
      repeat (bt) @(posedge mclk_i);
    end
  endtask
  // two data bytes then the check word, optionally corrupted
  task automatic blk(input logic [7:0] d0, input logic [7:0] d1,
                     input logic [7:0] x);
    logic [15:0] c;
    c = crc(crc(CRC_INIT, d0), d1);
    stx(d0, 1'b0);
    stx(d1, 1'b0);
    stx(c[15:8] ^ x, 1'b0);
    stx(c[7:0], 1'b0);
    idle(200);
  endtask
  initial
  begin
    logic [7:0] d0, d1;
    logic [7:0] q[5];
    logic [25:0] s;
    logic [2:0] kb;
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    adr = 8'($random(seed));
    get(1'b1, 1'b0, 8'h04);
    // every frame shape; parity always beside check enable
    for (int k = 0; k < 8; k++)
    begin
      kb = k[2:0];
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      cfg({2'b00, kb[2], kb[0] ^ kb[2], kb[1], kb[1], 2'b00},
          {5'h00, kb[0], 2'b00}, {7'h00, kb[0]});
      put(1'b1, {7'h20, kb[0]});
      fork
        samp(10 + kb[0] + kb[1] + kb[2], 16 * (kb[0] + 1), s);
        begin
          put(1'b0, d0);
          idle(4);
          put(1'b0, d1);
        end
      join
      chk(16'(s[12:0]), 16'(frm(d0, 1'b1)));
      chk(16'(s[25:13]), 16'(frm(d1, !wk)));
      idle(10);
      chk(16'({rxq[0], rxq[1]}), {d0, d1});
      rxq.delete();
    end
    // check word sent after a two-byte block
    cfg(8'h04, 8'h00, 8'h00);
    put(1'b1, 8'h41);
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    put(1'b0, d0);
    idle(4);
    put(1'b0, d1);
    idle(700);
    chk({rxq[2], rxq[3]}, crc(crc(CRC_INIT, d0), d1));
    chk(16'(rxq.size()), 16'h0004);
    blk(d0, d1, 8'h00);
    get(1'b1, 1'b0, 8'h05);
    get(1'b0, 1'b0, d0);
    get(1'b0, 1'b0, d1);
    blk(d1, d0, 8'h10);
    get(1'b1, 1'b0, 8'h45);
    get(1'b0, 1'b0, d1);
    get(1'b0, 1'b0, d0);
    // parity mismatch, flag held until cleared
    cfg(8'h08, 8'h00, 8'h00);
    po <= 1'b1;
    stx(d0, 1'b0);
    idle(200);
    get(1'b1, 1'b0, 8'h25);
    get(1'b0, 1'b0, d0);
    get(1'b1, 1'b0, 8'h24);
    put(1'b1, 8'h90);
    get(1'b1, 1'b0, 8'h04);
    // five bytes into a four-deep queue
    cfg(8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      q[i] = 8'($random(seed));
      stx(q[i], 1'b0);
    end
    idle(200);
    get(1'b1, 1'b0, 8'h17);
    for (int i = 0; i < 4; i++)
      get(1'b0, 1'b0, q[i]);
    get(1'b0, 1'b0, 8'h00);
    get(1'b1, 1'b0, 8'h14);
    // wakeup: foreign address, dropped byte, own address, data
    cfg(8'h00, 8'h04, 8'h00);
    stx(adr ^ 8'h01, 1'b1);
    stx(d0, 1'b0);
    stx(adr, 1'b1);
    stx(d1, 1'b0);
    idle(250);
    get(1'b0, 1'b0, adr ^ 8'h01);
    get(1'b0, 1'b0, adr);
    get(1'b0, 1'b0, d1);
    get(1'b1, 1'b0, 8'h04);
    // missing stop bit on the second device
    cfg(8'h00, 8'h00, 8'h00);
    bang({1'b0, d0, 1'b0});
    idle(40);
    get(1'b1, 1'b1, 8'h0d);
    get(1'b0, 1'b1, d0);
    wrap_up();
  end
endmodule
